// ---- rtl/acr_pkg.sv ----
// Constants and decode shared by both ends of the serial register link
//------------------------------------------------------------
// Functional notes
// - Transactions start with 8-bit command write
// - Command picks direction and target register
// - Return to command wait after access, reset
// - 32 rising-clock ones on din reset all; the result register keeps its value
// - Most significant bit travels first
// - Leading one holds position; zero starts command
// - Host always writes zero to bit six
// - Select bits pick status, mode, reserved, data
// - Bit three: zero write, one read
// - Continuous mode streams results without commands
// - Host enters continuous mode with 001111XX
// - Host exits with 001110XX while line low
// - Continuous mode still resets on 32 ones
// - Host keeps din low in continuous mode
// - Channel bits pick input, short, supply monitor
// - Channel change restarts filter and conversion
// - Command register clears to zero at reset
// - Output changes on serial clock falling edge
// - Select high releases output; ready keeps running
// - Select is active low; may stay tied low
//------------------------------------------------------------
package acr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SCLK_HALF_NS  = 800;
	localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);
	localparam int unsigned CMD_W  = 8;
	localparam int unsigned DATA_W = 24;
	localparam logic [5:0]  RESYNC_LAST = 6'h1F;
	// Command field positions
	localparam int unsigned CMD_WEN   = 7;
	localparam int unsigned CMD_ZERO  = 6;
	localparam int unsigned CMD_RS_HI = 5;
	localparam int unsigned CMD_RS_LO = 4;
	localparam int unsigned CMD_DIR   = 3;
	localparam int unsigned CMD_CONTINUOUS_RESULT_READ = 2;
	localparam int unsigned CMD_CH_HI = 1;
	localparam int unsigned CMD_CH_LO = 0;
	localparam logic [7:0]  CMD_RST   = 8'h00;
	localparam logic [7:0]  CMD_MASK  = 8'h3F;
	localparam logic [5:0]  CONT_ENTER = 6'h0F;
	localparam logic [5:0]  CONT_EXIT  = 6'h0E;
	// Register select and channel codes
	localparam logic [1:0]  SEL_STATUS = 2'h0;
	localparam logic [1:0]  SEL_MODE   = 2'h1;
	localparam logic [1:0]  SEL_RSVD   = 2'h2;
	localparam logic [1:0]  SEL_DATA   = 2'h3;
	localparam logic [1:0]  CH_DIFF    = 2'h0;
	localparam logic [1:0]  CH_RSVD    = 2'h1;
	localparam logic [1:0]  CH_SHORT   = 2'h2;
	localparam logic [1:0]  CH_SUPPLY  = 2'h3;
	localparam logic [7:0]  MODE_RST     = 8'h02;
	localparam logic [7:0]  STATUS_FIXED = 8'h0C;
	// Host register map (byte offsets) and fields
	localparam logic [7:0]  HOST_CMD_OFS   = 8'h00;
	localparam logic [7:0]  HOST_WDATA_OFS = 8'h04;
	localparam logic [7:0]  HOST_RDATA_OFS = 8'h08;
	localparam logic [7:0]  HOST_STAT_OFS  = 8'h0C;
	localparam logic [1:0]  OP_XFER   = 2'h0;
	localparam logic [1:0]  OP_RESYNC = 2'h1;
	localparam logic [1:0]  OP_FETCH  = 2'h2;
	localparam int unsigned HST_BUSY = 0;
	localparam int unsigned HST_CONT = 1;
	localparam int unsigned HST_LINE = 2;
	localparam int unsigned HST_DONE = 3;

	// Bits in the data phase of a register
	function automatic logic [4:0] acr_len(input logic [1:0] sel);
		return (sel == SEL_DATA) ? 5'h18 : 5'h08;
	endfunction
endpackage

// ---- rtl/acr_link_if.sv ----
// Serial link between host controller and converter front end
`timescale 1ns/1ps
`default_nettype none
interface acr_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout_o;
	logic dout_oe_n;
	logic dout;

	// Released line reads high through the board pull-up
	assign dout = dout_oe_n ? 1'b1 : dout_o;

	modport dev (input sclk, input cs_n, input din, output dout_o, output dout_oe_n);
	modport host (output sclk, output cs_n, output din, input dout);
endinterface
`default_nettype wire

// ---- rtl/acr_sync.sv ----
// Two-stage synchroniser with edge pulses
`timescale 1ns/1ps
`default_nettype none
module acr_sync #(
	parameter int unsigned W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         i_clock,  // System clock
	input  wire logic         i_rst_n,  // Async reset
	input  wire logic [W-1:0] i_async,  // Foreign inputs
	output logic      [W-1:0] o_level,  // Synchronised level
	output logic      [W-1:0] o_rise,   // Rising pulse
	output logic      [W-1:0] o_fall    // Falling pulse
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} acr_sync_st_t;

	acr_sync_st_t r_reg;
	acr_sync_st_t r_next;

	always_comb begin
		r_next      = r_reg;
		r_next.meta = i_async;
		r_next.sync = r_reg.meta;
		r_next.prev = r_reg.sync;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg <= '{meta: INIT, sync: INIT, prev: INIT};
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_level = r_reg.sync;
	assign o_rise  = r_reg.sync & ~r_reg.prev;
	assign o_fall  = ~r_reg.sync & r_reg.prev;
endmodule
`default_nettype wire

// ---- rtl/acr_dev.sv ----
// Converter end: serial command decoder and register access
`timescale 1ns/1ps
`default_nettype none
module acr_dev
	import acr_pkg::*;
(
	input  wire logic              i_clock,          // 10 MHz clock
	input  wire logic              i_rst_n,          // Async reset
	acr_link_if.dev                link,             // Serial link
	input  wire logic [DATA_W-1:0] i_result,         // Conversion result
	input  wire logic              i_result_valid,   // Result strobe
	output logic      [CMD_W-1:0]  o_mode,           // Mode register
	output logic      [1:0]        o_channel,        // Selected channel
	output logic                   o_cont_read,      // Streaming active
	output logic                   o_filter_restart, // Restart pulse
	output logic                   o_soft_reset,     // Full reset pulse
	output logic                   o_rdy_n           // Ready bit
);
	typedef enum logic [2:0] {DS_WEN, DS_CMD, DS_WR, DS_RD, DS_CONT} acr_dstate_t;

	typedef struct packed {
		acr_dstate_t       st;
		logic [CMD_W-1:0]  cmd;
		logic [CMD_W-1:0]  mode;
		logic [DATA_W-1:0] result;
		logic [DATA_W-1:0] shin;
		logic [DATA_W-1:0] shout;
		logic [4:0]        bits;
		logic [4:0]        len;
		logic [5:0]        ones;
		logic              rdy_n;
		logic              dout;
		logic              dout_oe_n;
		logic              filter_restart;
		logic              soft_reset;
		logic              cont;
	} acr_dev_st_t;

	localparam acr_dev_st_t DEV_RST = '{
		st:        DS_WEN,
		cmd:       CMD_RST,
		mode:      MODE_RST,
		rdy_n:     1'b1,
		dout:      1'b1,
		dout_oe_n: 1'b1,
		default:   '0
	};

	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	logic [2:0] pin_level;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	acr_sync #(
		.W    (3),
		.INIT (3'h6)
	) u_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async ({link.sclk, link.cs_n, link.din}),
		.o_level (pin_level),
		.o_rise  (pin_rise),
		.o_fall  (pin_fall)
	);

	logic cs_n_s;
	logic din_s;
	logic rise;
	logic fall;

	assign cs_n_s = pin_level[1];
	assign din_s  = pin_level[0];
	assign rise   = pin_rise[2] & ~cs_n_s;
	assign fall   = pin_fall[2] & ~cs_n_s;

	// Status byte as shifted out
	function automatic logic [7:0] status_byte(input logic rdy_n, input logic [1:0] ch);
		return STATUS_FIXED | {rdy_n, 5'h00, ch};
	endfunction

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	acr_dev_st_t r_reg;
	acr_dev_st_t r_next;
	logic [7:0]  new_cmd;
	logic [1:0]  sel;
	logic [1:0]  cur_sel;
	logic [DATA_W-1:0] win;

	assign cur_sel = r_reg.cmd[CMD_RS_HI:CMD_RS_LO];

	always_comb begin
		r_next = r_reg;
		new_cmd = {1'b0, r_reg.shin[5:0], din_s};
		sel = new_cmd[CMD_RS_HI:CMD_RS_LO];
		win = {r_reg.shin[DATA_W-2:0], din_s};
		r_next.filter_restart = 1'b0;
		r_next.soft_reset = 1'b0;
		r_next.dout_oe_n = cs_n_s;
		if (rise && din_s && r_reg.ones == RESYNC_LAST) begin
			r_next = DEV_RST;
			r_next.result = r_reg.result;
			r_next.soft_reset = 1'b1;
		end else if (rise) begin
			r_next.ones = din_s ? r_reg.ones + 6'h01 : 6'h00;
			unique case (r_reg.st)
				DS_WEN: begin
					if (!din_s) begin
						r_next.st = DS_CMD;
						r_next.bits = 5'h00;
					end
				end
				DS_CMD: begin
					r_next.shin = win;
					r_next.bits = r_reg.bits + 5'h01;
					if (r_reg.bits == 5'h06) begin
						r_next.cmd = new_cmd;
						r_next.bits = 5'h00;
						r_next.len = acr_len(sel);
						if (new_cmd[CMD_CH_HI:CMD_CH_LO] != r_reg.cmd[CMD_CH_HI:CMD_CH_LO]) begin
							r_next.filter_restart = 1'b1;
						end
						if (new_cmd[CMD_DIR]) begin
							r_next.st = DS_RD;
							unique case (sel)
								SEL_STATUS: r_next.shout = {status_byte(r_reg.rdy_n,
									new_cmd[CMD_CH_HI:CMD_CH_LO]), 16'h0000};
								SEL_MODE: r_next.shout = {r_reg.mode, 16'h0000};
								SEL_RSVD: r_next.shout = 24'h00_0000;
								SEL_DATA: r_next.shout = r_reg.result;
							endcase
							if (sel == SEL_DATA && new_cmd[CMD_CONTINUOUS_RESULT_READ]) begin
								r_next.st = DS_CONT;
								r_next.shin = 24'h00_0000;
							end
						end else if (sel == SEL_STATUS) begin
							r_next.st = DS_WEN;
						end else begin
							r_next.st = DS_WR;
						end
					end
				end
				DS_WR: begin
					r_next.shin = win;
					r_next.bits = r_reg.bits + 5'h01;
					if (r_reg.bits == r_reg.len - 5'h01) begin
						r_next.st = DS_WEN;
						if (cur_sel == SEL_MODE) begin
							r_next.mode = win[7:0];
							r_next.filter_restart = 1'b1;
							r_next.rdy_n = 1'b1;
						end
					end
				end
				DS_RD: begin
					r_next.bits = r_reg.bits + 5'h01;
					if (r_reg.bits == r_reg.len - 5'h01) begin
						r_next.st = DS_WEN;
						if (cur_sel == SEL_DATA) begin
							r_next.rdy_n = 1'b1;
						end
					end
				end
				DS_CONT: begin
					// Sliding window so leading zeros never misalign the exit
					r_next.shin = win;
					if (r_reg.bits == 5'h18) begin
						r_next.bits = 5'h00;
						r_next.rdy_n = 1'b1;
					end
					if (win[7:2] == CONT_EXIT) begin
						r_next.st = DS_WEN;
						r_next.cmd = win[7:0];
						r_next.bits = 5'h00;
						if (win[1:0] != r_reg.cmd[CMD_CH_HI:CMD_CH_LO]) begin
							r_next.filter_restart = 1'b1;
						end
					end
				end
				default: r_next.st = DS_WEN;
			endcase
		end else if (fall) begin
			if (r_reg.st == DS_RD) begin
				r_next.dout = r_reg.shout[DATA_W-1];
				r_next.shout = {r_reg.shout[DATA_W-2:0], 1'b0};
			end else if (r_reg.st == DS_CONT && r_reg.bits == 5'h00 && !r_reg.rdy_n) begin
				r_next.dout = r_reg.result[DATA_W-1];
				r_next.shout = {r_reg.result[DATA_W-2:0], 1'b0};
				r_next.bits = 5'h01;
			end else if (r_reg.st == DS_CONT && r_reg.bits != 5'h00 && r_reg.bits != 5'h18) begin
				r_next.dout = r_reg.shout[DATA_W-1];
				r_next.shout = {r_reg.shout[DATA_W-2:0], 1'b0};
				r_next.bits = r_reg.bits + 5'h01;
			end
		end
		// New result clears ready after any set in the same cycle
		if (i_result_valid) begin
			r_next.result = i_result;
			r_next.rdy_n = 1'b0;
		end
		// Between words the line shows ready
		if (!(r_next.st == DS_RD || (r_next.st == DS_CONT && r_next.bits != 5'h00))) begin
			r_next.dout = r_next.rdy_n;
		end
		// Registered so the streaming flag leaves a flip-flop
		r_next.cont = (r_next.st == DS_CONT);
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg <= DEV_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign link.dout_o       = r_reg.dout;
	assign link.dout_oe_n    = r_reg.dout_oe_n;
	assign o_mode            = r_reg.mode;
	assign o_channel         = r_reg.cmd[CMD_CH_HI:CMD_CH_LO];
	assign o_cont_read       = r_reg.cont;
	assign o_filter_restart  = r_reg.filter_restart;
	assign o_soft_reset      = r_reg.soft_reset;
	assign o_rdy_n           = r_reg.rdy_n;
endmodule
`default_nettype wire

// ---- rtl/acr_host.sv ----
// Host end: APB-driven serial command engine
`timescale 1ns/1ps
`default_nettype none
module acr_host
	import acr_pkg::*;
(
	input  wire logic        i_clock,   // 10 MHz clock, also APB clock
	input  wire logic        i_rst_n,   // Async reset
	input  wire logic        i_psel,    // APB select
	input  wire logic        i_penable, // APB enable
	input  wire logic        i_pwrite,  // APB direction
	input  wire logic [7:0]  i_paddr,   // APB byte address
	input  wire logic [31:0] i_pwdata,  // APB write data
	output logic      [31:0] o_prdata,  // APB read data
	output logic             o_pready,  // APB ready
	output logic             o_pslverr, // APB error
	acr_link_if.host         link       // Serial link
);
	typedef enum logic [2:0] {HS_IDLE, HS_WAIT, HS_LEAD, HS_SHIFT, HS_TAIL} acr_hstate_t;

	typedef struct packed {
		acr_hstate_t st;
		logic [3:0]  div;
		logic        sclk;
		logic        cs_n;
		logic        din;
		logic [31:0] tx;
		logic [23:0] rx;
		logic [5:0]  bits;
		logic [5:0]  total;
		logic        len8;
		logic        cont;
		logic        cont_end;
		logic        done;
		logic [23:0] wdata;
		logic [23:0] rdata;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} acr_host_st_t;

	localparam acr_host_st_t HOST_RST = '{st: HS_IDLE, sclk: 1'b1, cs_n: 1'b1, default: '0};

	logic dout_s;

	acr_sync #(
		.W    (1),
		.INIT (1'b1)
	) u_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async (link.dout),
		.o_level (dout_s),
		.o_rise  (),
		.o_fall  ()
	);

	acr_host_st_t r_reg;
	acr_host_st_t r_next;
	logic [7:0]   c;
	logic [4:0]   len;
	logic         acc;

	always_comb begin
		r_next = r_reg;
		c = i_pwdata[7:0] & CMD_MASK;
		len = acr_len(c[CMD_RS_HI:CMD_RS_LO]);
		acc = i_psel & i_penable & r_reg.pready;
		r_next.pready = i_psel & i_penable & ~r_reg.pready;
		if (i_psel && i_penable && !r_reg.pready) begin
			r_next.pslverr = 1'b0;
			unique case (i_paddr)
				HOST_WDATA_OFS: r_next.prdata = {8'h00, r_reg.wdata};
				HOST_RDATA_OFS: r_next.prdata = {8'h00, r_reg.rdata};
				HOST_STAT_OFS: r_next.prdata = {28'h000_0000, r_reg.done, dout_s,
					r_reg.cont, r_reg.st != HS_IDLE};
				HOST_CMD_OFS: r_next.prdata = 32'h0000_0000;
				default: begin
					r_next.prdata = 32'h0000_0000;
					r_next.pslverr = 1'b1;
				end
			endcase
		end
		if (acc && i_pwrite) begin
			if (i_paddr == HOST_WDATA_OFS) begin
				r_next.wdata = i_pwdata[23:0];
			end
			if (i_paddr == HOST_STAT_OFS && i_pwdata[HST_DONE]) begin
				r_next.done = 1'b0;
			end
			if (i_paddr == HOST_CMD_OFS && r_reg.st == HS_IDLE) begin
				r_next.cs_n = 1'b0;
				r_next.div = 4'h0;
				r_next.bits = 6'h00;
				r_next.st = HS_LEAD;
				r_next.cont_end = r_reg.cont;
				r_next.len8 = (len == 5'h08);
				unique case (i_pwdata[9:8])
					OP_RESYNC: begin
						r_next.tx = 32'hFFFF_FFFF;
						r_next.total = 6'h20;
						r_next.cont_end = 1'b0;
					end
					OP_FETCH: begin
						r_next.tx = 32'h0000_0000;
						r_next.total = 6'h18;
						r_next.len8 = 1'b0;
						r_next.st = HS_WAIT;
					end
					default: begin
						r_next.tx = {c, c[CMD_DIR] ? 24'h00_0000 :
							(r_next.len8 ? {r_reg.wdata[7:0], 16'h0000} : r_reg.wdata)};
						r_next.total = {1'b0, len} + 6'h08;
						if (c[CMD_DIR] == 1'b0 && c[CMD_RS_HI:CMD_RS_LO] == SEL_STATUS) begin
							r_next.total = 6'h08;
						end
						if (c[7:2] == CONT_ENTER) begin
							r_next.total = 6'h08;
							r_next.cont_end = 1'b1;
						end
						if (r_reg.cont && c[7:2] == CONT_EXIT) begin
							r_next.cont_end = 1'b0;
							r_next.st = HS_WAIT;
						end
					end
				endcase
			end
		end
		unique case (r_reg.st)
			HS_IDLE: r_next.din = 1'b0;
			HS_WAIT: begin
				if (!dout_s) begin
					r_next.st = HS_LEAD;
					r_next.div = 4'h0;
				end
			end
			HS_LEAD: begin
				r_next.div = r_reg.div + 4'h1;
				if (r_reg.div == SCLK_HALF_LAST) begin
					r_next.st = HS_SHIFT;
					r_next.div = 4'h0;
				end
			end
			HS_SHIFT: begin
				r_next.div = r_reg.div + 4'h1;
				if (r_reg.div == SCLK_HALF_LAST) begin
					r_next.div = 4'h0;
					r_next.sclk = ~r_reg.sclk;
					if (r_reg.sclk) begin
						r_next.din = r_reg.tx[31];
						r_next.tx = {r_reg.tx[30:0], 1'b0};
					end else begin
						r_next.rx = {r_reg.rx[22:0], dout_s};
						r_next.bits = r_reg.bits + 6'h01;
						if (r_reg.bits == r_reg.total - 6'h01) begin
							r_next.st = HS_TAIL;
						end
					end
				end
			end
			HS_TAIL: begin
				r_next.div = r_reg.div + 4'h1;
				if (r_reg.div == SCLK_HALF_LAST) begin
					r_next.st = HS_IDLE;
					r_next.cs_n = 1'b1;
					r_next.din = 1'b0;
					r_next.done = 1'b1;
					r_next.cont = r_reg.cont_end;
					r_next.rdata = r_reg.len8 ? {16'h0000, r_reg.rx[7:0]} : r_reg.rx;
				end
			end
			default: r_next.st = HS_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg <= HOST_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.sclk = r_reg.sclk;
	assign link.cs_n = r_reg.cs_n;
	assign link.din  = r_reg.din;
	assign o_prdata  = r_reg.prdata;
	assign o_pready  = r_reg.pready;
	assign o_pslverr = r_reg.pslverr;
endmodule
`default_nettype wire

// ---- dv/acr_asserts.sv ----
// Concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module acr_asserts (
	input wire logic i_clock,     // System clock
	input wire logic i_rst_n,     // Async reset
	input wire logic i_sclk,      // Serial clock
	input wire logic i_cs_n,      // Select
	input wire logic i_din,       // Host data
	input wire logic i_dout_o,    // Device data
	input wire logic i_dout_oe_n  // Device enable, low drives
);
	default clocking dc @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	a_sclk_idle_high: assert property (i_cs_n |-> i_sclk)
		else $error("serial clock low outside a frame");
	a_lead_time: assert property ($fell(i_cs_n) |-> i_sclk [*8])
		else $error("serial clock moved too soon after select");
	a_low_half: assert property ($fell(i_sclk) |-> (!i_sclk) [*8] ##1 i_sclk)
		else $error("serial clock low half has wrong length");
	a_high_half: assert property ($rose(i_sclk) |-> i_sclk [*8])
		else $error("serial clock high half too short");
	// Host data must not move while the device may be sampling
	a_din_steady: assert property (!i_cs_n && !$past(i_cs_n) && i_sclk && $past(i_sclk)
		|-> $stable(i_din))
		else $error("host data changed while serial clock high");
	a_dout_launch: assert property ($rose(i_sclk) && !i_cs_n |=> $stable(i_dout_o))
		else $error("device data changed after a rising serial edge");
	a_release_soon: assert property ($rose(i_cs_n) |-> ##[1:6] i_dout_oe_n)
		else $error("device kept driving after deselect");
	a_drive_selected: assert property ($fell(i_dout_oe_n) |-> !i_cs_n && !$past(i_cs_n))
		else $error("device drove the line while not selected");
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Testbench joining host and converter ends across the serial link
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench
	import acr_pkg::*;
;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] wd;
		logic       rd;
		logic [7:0] exp;
		logic [1:0] fr;
	} acr_row_t;
	logic        i_clock;
	logic        i_rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [23:0] result;
	logic        result_valid;
	logic [7:0]  mode;
	logic [1:0]  channel;
	logic        cont_read;
	logic        filter_restart;
	logic        soft_reset;
	logic        rdy_n;
	logic        sck_q;
	logic        cs_q;
	logic [7:0]  fb = 8'h00;
	int          nbits = 0;
	int          miscompares = 0;
	int          compares = 0;
	int          restarts = 0;
	int          resets = 0;
	acr_row_t    rows [12] = '{
		'{8'h18, 8'h00, 1'b1, 8'h02, 2'h0},
		'{8'h10, 8'h06, 1'b0, 8'h00, 2'h1},
		'{8'h19, 8'h00, 1'b1, 8'h06, 2'h1},
		'{8'h0A, 8'h00, 1'b1, 8'h8E, 2'h1},
		'{8'h0B, 8'h00, 1'b1, 8'h8F, 2'h1},
		'{8'h20, 8'hFF, 1'b0, 8'h00, 2'h1},
		'{8'h08, 8'h00, 1'b1, 8'h8C, 2'h0},
		'{8'h31, 8'hFF, 1'b0, 8'h00, 2'h1},
		'{8'h09, 8'h00, 1'b1, 8'h8D, 2'h0},
		'{8'h02, 8'h00, 1'b0, 8'h00, 2'h1},
		'{8'h0A, 8'h00, 1'b1, 8'h8E, 2'h0},
		'{8'h2A, 8'h00, 1'b1, 8'h00, 2'h0}
	};

	acr_link_if acr_link_if_i ();
	acr_host acr_host_i (
		.i_clock   (i_clock),
		.i_rst_n   (i_rst_n),
		.i_psel    (psel),
		.i_penable (penable),
		.i_pwrite  (pwrite),
		.i_paddr   (paddr),
		.i_pwdata  (pwdata),
		.o_prdata  (prdata),
		.o_pready  (pready),
		.o_pslverr (pslverr),
		.link      (acr_link_if_i)
	);
	acr_dev acr_dev_i (
		.i_clock          (i_clock),
		.i_rst_n          (i_rst_n),
		.link             (acr_link_if_i),
		.i_result         (result),
		.i_result_valid   (result_valid),
		.o_mode           (mode),
		.o_channel        (channel),
		.o_cont_read      (cont_read),
		.o_filter_restart (filter_restart),
		.o_soft_reset     (soft_reset),
		.o_rdy_n          (rdy_n)
	);
	acr_asserts acr_asserts_i (
		.i_clock   (i_clock),
		.i_rst_n   (i_rst_n),
		.i_sclk      (acr_link_if_i.sclk),
		.i_cs_n      (acr_link_if_i.cs_n),
		.i_din       (acr_link_if_i.din),
		.i_dout_o    (acr_link_if_i.dout_o),
		.i_dout_oe_n (acr_link_if_i.dout_oe_n)
	);

	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	// ----------------------------------------
	// Wire monitor: first byte and bit count of each frame
	// ----------------------------------------
	always @(posedge i_clock) begin
		sck_q <= acr_link_if_i.sclk;
		cs_q <= acr_link_if_i.cs_n;
		if (filter_restart === 1'b1)
			restarts++;
		if (soft_reset === 1'b1)
			resets++;
		if (!acr_link_if_i.cs_n && cs_q)
			nbits = 0;
		else if (!acr_link_if_i.cs_n && acr_link_if_i.sclk && !sck_q) begin
			if (nbits < 8)
				fb = {fb[6:0], acr_link_if_i.din};
			nbits++;
		end
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic give_up();
		miscompares++;
		$display("MISMATCH at %0t: wait ran out", $time);
		summarize();
	endtask

	task automatic ends(input string s);
		$display("test %s done at %0t", s, $time);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (pready !== 1'b1 && n < 100);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clock);
		if (n >= 100)
			give_up();
	endtask

	task automatic xfer(input logic [1:0] op, input logic [7:0] cmd, input logic [23:0] wd,
		output logic [31:0] r);
		logic [31:0] st;
		logic        e;
		int          n;
		apb(1'b1, HOST_WDATA_OFS, {8'h00, wd}, st, e);
		apb(1'b1, HOST_CMD_OFS, {22'h00_0000, op, cmd}, st, e);
		n = 0;
		do begin
			apb(1'b0, HOST_STAT_OFS, 32'h0000_0000, st, e);
			n++;
		end while (st[HST_DONE] !== 1'b1 && n < 1000);
		if (n >= 1000)
			give_up();
		apb(1'b1, HOST_STAT_OFS, 32'h0000_0008, st, e);
		apb(1'b0, HOST_RDATA_OFS, 32'h0000_0000, r, e);
	endtask

	task automatic give_result(input logic [23:0] v);
		result <= v;
		result_valid <= 1'b1;
		@(posedge i_clock);
		result_valid <= 1'b0;
		@(posedge i_clock);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] res;
		logic        err;
		int          fr0;
		int          sr0;
		i_rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		result = 24'h00_0000;
		result_valid = 1'b0;
		repeat (16) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		foreach (rows[k]) begin
			fr0 = restarts;
			xfer(OP_XFER, rows[k].cmd, {16'h0000, rows[k].wd}, res);
			if (rows[k].rd)
				`CHECK(res[7:0], rows[k].exp)
			`CHECK(fb, rows[k].cmd)
			// Status-address writes end after the command byte
			`CHECK(nbits, 8 + ((rows[k].cmd[5:4] == 2'h3) ? 24 : (rows[k].cmd[5:3] == 3'h0) ? 0 : 8))
			`CHECK(channel, rows[k].cmd[1:0])
			`CHECK(2'(restarts - fr0), rows[k].fr)
		end
		`CHECK(mode, 8'h06)
		ends("register table");
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		`CHECK(mode, MODE_RST)
		`CHECK(channel, CH_DIFF)
		`CHECK(acr_link_if_i.dout_oe_n, 1'b1)
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		xfer(OP_XFER, 8'h08, 24'h00_0000, res);
		`CHECK(res[7:0], 8'h8C)
		ends("reset");
		give_result(24'h5A_C3E1);
		`CHECK(rdy_n, 1'b0)
		xfer(OP_XFER, 8'h08, 24'h00_0000, res);
		`CHECK(res[7:0], 8'h0C)
		xfer(OP_XFER, 8'h38, 24'h00_0000, res);
		`CHECK(res[23:0], 24'h5A_C3E1)
		xfer(OP_XFER, 8'h08, 24'h00_0000, res);
		`CHECK(res[7:0], 8'h8C)
		ends("data read");
		xfer(OP_XFER, 8'h3F, 24'h00_0000, res);
		`CHECK(cont_read, 1'b1)
		give_result(24'h12_3456);
		xfer(OP_FETCH, 8'h00, 24'h00_0000, res);
		`CHECK(res[23:0], 24'h12_3456)
		sr0 = resets;
		xfer(OP_RESYNC, 8'h00, 24'h00_0000, res);
		`CHECK(resets - sr0, 1)
		`CHECK(cont_read, 1'b0)
		`CHECK(channel, CH_DIFF)
		xfer(OP_XFER, 8'h3C, 24'h00_0000, res);
		give_result(24'hA5_0F0F);
		xfer(OP_XFER, 8'h38, 24'h00_0000, res);
		`CHECK(cont_read, 1'b0)
		xfer(OP_XFER, 8'h18, 24'h00_0000, res);
		`CHECK(res[7:0], MODE_RST)
		ends("continuous");
		apb(1'b0, 8'h10, 32'h0000_0000, res, err);
		`CHECK(err, 1'b1)
		`CHECK(res, 32'h0000_0000)
		ends("unmapped");
		xfer(OP_XFER, 8'hD9, 24'h00_0000, res);
		`CHECK(fb, 8'h19)
		ends("forced bits");
		summarize();
	end
endmodule
`default_nettype wire
